/* File: verilog/ead_defs.svh */
// How it works
// [RULE_01] Cycle charge counts four clocks per bus access; wait states stretch it.
// [RULE_02] Charge covers opcode fetch plus every operand read and result store.
// [RULE_03] Each addressing mode maps to its data, memory, control, alterable categories.
// [RULE_04] Modes 000-110 use register field; mode 111 selects absolute or PC forms.
// [RULE_05] Decimal add sums destination, source and extend; sets X, Z, C.
// [RULE_06] Decimal subtract and negate in BCD; set X, Z, C; N, V undefined.
// [RULE_07] Bit tests put inverted bit in Z; set, clear, invert variants modify it.
// [RULE_08] Bounds check traps below zero or above bound; N updated, X kept.
// [RULE_09] Loop branch: false condition decrements counter, branches unless it hits -1.
// [RULE_10] Test-and-mark sets N, Z, clears V, C, then sets bit 7.
// [RULE_11] Move copies source, sets N, Z, clears V and C, keeps X.
// [RULE_12] Subtract with extend stores dst-src-X and updates all five flags.
// [RULE_13] Immediate AND, OR, XOR combine with condition byte or status word.
// [RULE_14] Move to status word loads all flags; move from it changes none.
// [RULE_15] Stop loads status word from immediate, then halts execution.
// [RULE_16] Return-restore pops condition byte first, then program counter.
// [RULE_17] Swap exchanges register halves; N, Z from result, V, C cleared.
// [RULE_18] Set-on-condition writes ones or zeros to a byte; flags unchanged.
// [RULE_19] Frame link pushes register, copies stack pointer, adds displacement.
// [RULE_20] Execution starts only with opcode and following word held in prefetch.
// [RULE_21] Supervisor bit picks stack pointer; traps always use supervisor stack.
// [RULE_22] Disallowed or unassigned addressing modes are illegal, never executed.
`ifndef EAD_DEFS_SVH
`define EAD_DEFS_SVH
`define EAD_BUS_CLKS 10'h004
`define EAD_PF_WORDS 2'h2
`define EAD_X 4
`define EAD_N 3
`define EAD_Z 2
`define EAD_V 1
`define EAD_C 0
`define EAD_S_BIT 13
`define EAD_MARK_BIT 7
`define EAD_SR_RST 16'h2000
`define EAD_SP_PUSH 32'h00000004
`define EAD_CCR_POP 32'h00000002
`define EAD_PC_POP 32'h00000004
`define EAD_BCD_ADJ 4'h6
`define EAD_BCD_MAX 5'h09
`define EAD_CAT_DATA 3
`define EAD_CAT_MEM 2
`define EAD_CAT_CTL 1
`define EAD_CAT_ALT 0
`endif

/* File: verilog/ead_pkg.sv */
package ead_pkg;
   typedef enum logic [4:0] {
      op_move = 5'h00, op_subtract_with_extend = 5'h01, op_dec_add = 5'h02, op_dec_sub = 5'h03,
      op_dec_neg = 5'h04, op_bit_tst = 5'h05, op_bit_set = 5'h06, op_bit_clr = 5'h07,
      op_bit_inv = 5'h08, op_bounds = 5'h09, op_loop = 5'h0a, op_mark = 5'h0b,
      op_swap = 5'h0c, op_setcc = 5'h0d, op_and_ccr = 5'h0e, op_or_ccr = 5'h0f,
      op_xor_ccr = 5'h10, op_and_sr = 5'h11, op_or_sr = 5'h12, op_xor_sr = 5'h13,
      op_to_sr = 5'h14, op_from_sr = 5'h15, op_stop = 5'h16, op_rtr = 5'h17,
      op_link = 5'h18
   } ead_op_t;
   typedef enum logic [1:0] {
      sz_byte = 2'h0, sz_word = 2'h1, sz_long = 2'h2
   } ead_size_t;
   typedef enum logic [1:0] {
      s_idle = 2'h0, s_pop_pc = 2'h1, s_busy = 2'h2, s_halt = 2'h3
   } ead_state_t;
endpackage

/* File: verilog/ead_ea_decode.sv */
`include "ead_defs.svh"
module ead_ea_decode (
   // Mode and register fields
   input wire logic [2:0] mode,
   input wire logic [2:0] regf,
   // Categories
   output logic [3:0] cat,
   output logic valid
);
   wire m7 = mode == 3'h7;
   // --------
   // Field decode
   // --------
   // [RULE_04] Mode 111 uses register field
   assign valid = !m7 || regf <= 3'h4;
   // [RULE_03] Category membership
   assign cat[`EAD_CAT_DATA] = mode != 3'h1;
   assign cat[`EAD_CAT_MEM] = mode >= 3'h2;
   assign cat[`EAD_CAT_CTL] = mode == 3'h2 || mode == 3'h5 || mode == 3'h6 ||
      (m7 && regf != 3'h4);
   assign cat[`EAD_CAT_ALT] = !m7 || regf <= 3'h1;
endmodule

/* File: verilog/ead_bcd.sv */
`include "ead_defs.svh"
module ead_bcd (
   // Operands
   input wire logic [7:0] a,
   input wire logic [7:0] b,
   input wire logic x_in,
   input wire logic sub,
   // Result
   output logic [7:0] res,
   output logic carry
);
   wire [2:0] cy;
   assign cy[0] = x_in;
   // --------
   // Digit chain
   // --------
   for (genvar i = 0; i < 2; i++) begin : g_dig
      wire [4:0] da = {1'b0, a[4*i+3:4*i]};
      wire [4:0] db = {1'b0, b[4*i+3:4*i]};
      wire [4:0] raw = sub ? da - db - {4'h0, cy[i]} : da + db + {4'h0, cy[i]};
      wire adj = sub ? raw[4] : raw > `EAD_BCD_MAX;
      // [RULE_05] [RULE_06] Decimal digit adjust
      assign res[4*i+3:4*i] = !adj ? raw[3:0] :
         sub ? raw[3:0] - `EAD_BCD_ADJ : raw[3:0] + `EAD_BCD_ADJ;
      assign cy[i+1] = adj;
   end
   assign carry = cy[2];
endmodule

/* File: verilog/ead_exec.sv */
`include "ead_defs.svh"
module ead_exec (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Command
   input wire logic start,
   input wire ead_pkg::ead_op_t op,
   input wire ead_pkg::ead_size_t sz,
   input wire logic [1:0] pf_cnt,
   input wire logic resume,
   // Effective address
   input wire logic [2:0] ea_mode,
   input wire logic [2:0] ea_reg,
   input wire logic [3:0] req_cat,
   // Operands
   input wire logic [31:0] src,
   input wire logic [31:0] dst,
   input wire logic [15:0] imm,
   input wire logic [4:0] bit_num,
   input wire logic cond_true,
   input wire logic [15:0] sr_in,
   input wire logic [31:0] pc_in,
   input wire logic [31:0] sp_in,
   // Timing
   input wire logic [3:0] n_reads,
   input wire logic [3:0] n_writes,
   input wire logic [7:0] int_clks,
   input wire logic bus_wait,
   // Results
   output logic [31:0] res_q,
   output logic [15:0] sr_q,
   output logic [31:0] pc_q,
   output logic [31:0] sp_q,
   output logic [31:0] an_q,
   output logic [31:0] push_q,
   output logic sp_super_q,
   output logic trap_q,
   output logic illegal_q,
   output logic branch_q,
   // Status
   output logic done_q,
   output logic busy_q,
   output logic halted_q,
   output logic [9:0] cycles_q
);
   import ead_pkg::*;

   ead_state_t state_q, state_d;
   logic [9:0] rem_q;
   logic stop_q, w1_q, w2_q;
   logic [31:0] res_d, pc_d, sp_d, an_d, push_d;
   logic [15:0] sr_d;
   logic trap_d, br_d;

   // ----------------------------------------
   // Address mode check
   // ----------------------------------------
   wire [3:0] cat;
   wire ea_valid;
   ead_ea_decode u_ea (
      .mode(ea_mode),
      .regf(ea_reg),
      .cat(cat),
      .valid(ea_valid)
   );
   // [RULE_22] Refuse bad modes
   wire ill = !ea_valid || (req_cat & ~cat) != 4'h0;
   // [RULE_20] Both prefetch words held
   wire acc = start && state_q == s_idle && pf_cnt == `EAD_PF_WORDS;
   wire run = acc && !ill;

   // ----------------------------------------
   // Operand shaping
   // ----------------------------------------
   wire xf = sr_in[`EAD_X];
   wire [31:0] msk = sz == sz_byte ? 32'h000000ff :
      sz == sz_word ? 32'h0000ffff : 32'hffffffff;
   wire [4:0] top = sz == sz_byte ? 5'h07 : sz == sz_word ? 5'h0f : 5'h1f;
   wire [31:0] sm = src & msk;
   wire [31:0] dm = dst & msk;
   wire [31:0] keep = dst & ~msk;
   wire [32:0] dif = {1'b0, dm} - {1'b0, sm} - {32'h0, xf};
   wire [31:0] difm = dif[31:0] & msk;
   wire dif_c = dif[{1'b0, top} + 6'h01];
   wire dif_v = (dm[top] ^ sm[top]) & (dm[top] ^ difm[top]);

   // Decimal path shares one adder for all three forms
   wire [7:0] bcd_r;
   wire bcd_c;
   ead_bcd u_bcd (
      .a(op == op_dec_neg ? 8'h00 : dst[7:0]),
      .b(op == op_dec_neg ? dst[7:0] : src[7:0]),
      .x_in(xf),
      .sub(op != op_dec_add),
      .res(bcd_r),
      .carry(bcd_c)
   );

   // Register operands wrap the bit number at 32, memory bytes at 8
   wire [4:0] bi = ea_mode == 3'h0 ? bit_num : {2'h0, bit_num[2:0]};
   wire [31:0] bmask = 32'h00000001 << bi;
   wire bsel = dst[bi];
   wire bnd_lo = dst[15];
   wire bnd_hi = $signed(dst[15:0]) > $signed(src[15:0]);
   wire [15:0] lp_cnt = dst[15:0] - 16'h0001;
   wire [31:0] dsp = {{16{imm[15]}}, imm};
   wire [31:0] sp_push = sp_in - `EAD_SP_PUSH;
   wire [31:0] swp = {dst[15:0], dst[31:16]};
   wire [7:0] mark_b = dst[7:0];

   // ----------------------------------------
   // Operation and flag update
   // ----------------------------------------
   always_comb begin
      res_d = dst;
      sr_d = sr_in;
      pc_d = pc_in;
      sp_d = sp_in;
      an_d = an_q;
      push_d = push_q;
      trap_d = 1'b0;
      br_d = 1'b0;
      unique case (op)
         op_move: begin
            // [RULE_11] Copy and flag
            res_d = keep | sm;
            sr_d[`EAD_N] = sm[top];
            sr_d[`EAD_Z] = sm == 32'h0;
            sr_d[`EAD_V] = 1'b0;
            sr_d[`EAD_C] = 1'b0;
         end
         op_subtract_with_extend: begin
            // [RULE_12] All five flags
            res_d = keep | difm;
            sr_d[`EAD_X] = dif_c;
            sr_d[`EAD_C] = dif_c;
            sr_d[`EAD_N] = difm[top];
            sr_d[`EAD_Z] = difm == 32'h0;
            sr_d[`EAD_V] = dif_v;
         end
         op_dec_add, op_dec_sub, op_dec_neg: begin
            // [RULE_05] [RULE_06] Decimal flags
            res_d = {dst[31:8], bcd_r};
            sr_d[`EAD_X] = bcd_c;
            sr_d[`EAD_C] = bcd_c;
            if (bcd_r != 8'h00) begin
               sr_d[`EAD_Z] = 1'b0;
            end
         end
         op_bit_tst, op_bit_set, op_bit_clr, op_bit_inv: begin
            // [RULE_07] Inverted bit to zero flag
            sr_d[`EAD_Z] = !bsel;
            if (op == op_bit_set) begin
               res_d = dst | bmask;
            end else if (op == op_bit_clr) begin
               res_d = dst & ~bmask;
            end else if (op == op_bit_inv) begin
               res_d = dst ^ bmask;
            end
         end
         op_bounds: begin
            // [RULE_08] Trap out of range
            trap_d = bnd_lo || bnd_hi;
            sr_d[`EAD_N] = bnd_lo;
         end
         op_loop: begin
            // [RULE_09] Decrement and branch
            if (!cond_true) begin
               res_d = {dst[31:16], lp_cnt};
               br_d = lp_cnt != 16'hffff;
               pc_d = br_d ? pc_in + dsp : pc_in;
            end
         end
         op_mark: begin
            // [RULE_10] Test then mark bit
            res_d = dst;
            res_d[`EAD_MARK_BIT] = 1'b1;
            sr_d[`EAD_N] = mark_b[7];
            sr_d[`EAD_Z] = mark_b == 8'h00;
            sr_d[`EAD_V] = 1'b0;
            sr_d[`EAD_C] = 1'b0;
         end
         op_swap: begin
            // [RULE_17] Exchange halves
            res_d = swp;
            sr_d[`EAD_N] = swp[31];
            sr_d[`EAD_Z] = swp == 32'h0;
            sr_d[`EAD_V] = 1'b0;
            sr_d[`EAD_C] = 1'b0;
         end
         op_setcc: begin
            // [RULE_18] Byte of ones or zeros
            res_d = {dst[31:8], cond_true ? 8'hff : 8'h00};
         end
         // [RULE_13] Immediate logic on flags
         op_and_ccr: sr_d[7:0] = sr_in[7:0] & imm[7:0];
         op_or_ccr: sr_d[7:0] = sr_in[7:0] | imm[7:0];
         op_xor_ccr: sr_d[7:0] = sr_in[7:0] ^ imm[7:0];
         op_and_sr: sr_d = sr_in & imm;
         op_or_sr: sr_d = sr_in | imm;
         op_xor_sr: sr_d = sr_in ^ imm;
         // [RULE_14] Load or store status word
         op_to_sr: sr_d = src[15:0];
         op_from_sr: res_d = {dst[31:16], sr_in};
         // [RULE_15] Load then halt
         op_stop: sr_d = imm;
         op_rtr: begin
            // [RULE_16] Condition byte popped first
            sr_d[7:0] = src[7:0];
            sp_d = sp_in + `EAD_CCR_POP;
         end
         op_link: begin
            // [RULE_19] Push, copy, allocate
            push_d = src;
            an_d = sp_push;
            sp_d = sp_push + dsp;
         end
         default: begin
            res_d = dst;
         end
      endcase
   end

   // ----------------------------------------
   // Cycle charge
   // ----------------------------------------
   // [RULE_01] [RULE_02] Fetch, reads, writes at four clocks each
   wire [9:0] charge = `EAD_BUS_CLKS * (10'h001 + {6'h0, n_reads} + {6'h0, n_writes}) +
      {2'h0, int_clks};
   wire counting = state_q == s_pop_pc || state_q == s_busy;
   // [RULE_01] Wait states hold the count
   wire last = state_q == s_busy && !w2_q && rem_q == 10'h001;

   always_comb begin
      state_d = state_q;
      unique case (state_q)
         s_idle: begin
            if (acc) begin
               state_d = !ill && op == op_rtr ? s_pop_pc : s_busy;
            end
         end
         s_pop_pc: state_d = s_busy;
         s_busy: begin
            if (last) begin
               state_d = stop_q ? s_halt : s_idle;
            end
         end
         s_halt: begin
            if (resume) begin
               state_d = s_idle;
            end
         end
      endcase
   end

   // ----------------------------------------
   // Sequencer registers
   // ----------------------------------------
   // Pin input, two flops before use
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         w1_q <= 1'b0;
         w2_q <= 1'b0;
      end else begin
         w1_q <= bus_wait;
         w2_q <= w1_q;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_q <= s_idle;
         busy_q <= 1'b0;
         halted_q <= 1'b0;
         done_q <= 1'b0;
      end else begin
         state_q <= state_d;
         busy_q <= state_d == s_pop_pc || state_d == s_busy;
         halted_q <= state_d == s_halt;
         done_q <= last;
      end
   end

   // Illegal addressing modes still cost their own fetch
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rem_q <= 10'h000;
         cycles_q <= 10'h000;
      end else if (acc) begin
         rem_q <= ill ? `EAD_BUS_CLKS : charge;
         cycles_q <= 10'h000;
      end else if (counting) begin
         rem_q <= w2_q && state_q == s_busy ? rem_q : rem_q - 10'h001;
         cycles_q <= cycles_q + 10'h001;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         stop_q <= 1'b0;
         illegal_q <= 1'b0;
         trap_q <= 1'b0;
         branch_q <= 1'b0;
         sp_super_q <= 1'b1;
      end else if (acc) begin
         stop_q <= run && op == op_stop;
         illegal_q <= ill;
         trap_q <= run && trap_d;
         branch_q <= run && br_d;
         // [RULE_21] Traps force supervisor stack
         sp_super_q <= sr_in[`EAD_S_BIT] || ill || trap_d;
      end
   end

   // ----------------------------------------
   // Result registers
   // ----------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         res_q <= 32'h0;
         sr_q <= `EAD_SR_RST;
         an_q <= 32'h0;
         push_q <= 32'h0;
      end else if (run) begin
         res_q <= res_d;
         sr_q <= sr_d;
         an_q <= an_d;
         push_q <= push_d;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pc_q <= 32'h0;
         sp_q <= 32'h0;
      end else if (run) begin
         pc_q <= pc_d;
         sp_q <= sp_d;
      end else if (state_q == s_pop_pc) begin
         // [RULE_16] Program counter popped second
         pc_q <= res_q;
         sp_q <= sp_q + `EAD_PC_POP;
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   property p_pf_gate;
      @(posedge clk) disable iff (rst)
      state_q == s_idle && start && pf_cnt != `EAD_PF_WORDS |=> !busy_q;
   endproperty
   a_pf_gate: assert property (p_pf_gate) else $error("start without prefetch"); // [RULE_20]

   property p_wait_hold;
      @(posedge clk) disable iff (rst)
      state_q == s_busy && w2_q |=> rem_q == $past(rem_q) && busy_q;
   endproperty
   a_wait_hold: assert property (p_wait_hold) else $error("wait not held"); // [RULE_01]

   property p_charge;
      @(posedge clk) disable iff (rst)
      done_q |-> cycles_q >= `EAD_BUS_CLKS;
   endproperty
   a_charge: assert property (p_charge) else $error("charge too short"); // [RULE_02]

   property p_illegal;
      @(posedge clk) disable iff (rst)
      acc && ill |=> illegal_q && sp_super_q && sr_q == $past(sr_q) && res_q == $past(res_q);
   endproperty
   a_illegal: assert property (p_illegal) else $error("illegal executed"); // [RULE_22]

   property p_stop;
      @(posedge clk) disable iff (rst)
      run && op == op_stop |=> sr_q == $past(imm) ##0 stop_q;
   endproperty
   a_stop: assert property (p_stop) else $error("stop load wrong"); // [RULE_15]

   property p_rtr;
      @(posedge clk) disable iff (rst)
      run && op == op_rtr |=> state_q == s_pop_pc ##1 pc_q == $past(res_q) && busy_q;
   endproperty
   a_rtr: assert property (p_rtr) else $error("pop order wrong"); // [RULE_16]

   property p_swap;
      @(posedge clk) disable iff (rst)
      run && op == op_swap |=> res_q == {$past(dst[15:0]), $past(dst[31:16])}
         && !sr_q[`EAD_V] && !sr_q[`EAD_C];
   endproperty
   a_swap: assert property (p_swap) else $error("swap wrong"); // [RULE_17]

   property p_setcc;
      @(posedge clk) disable iff (rst)
      run && op == op_setcc |=> sr_q == $past(sr_in) && res_q[0] == $past(cond_true);
   endproperty
   a_setcc: assert property (p_setcc) else $error("set byte wrong"); // [RULE_18]

   property p_mark;
      @(posedge clk) disable iff (rst)
      run && op == op_mark |=> res_q[7] && sr_q[`EAD_Z] == ($past(dst[7:0]) == 8'h00);
   endproperty
   a_mark: assert property (p_mark) else $error("mark wrong"); // [RULE_10]

   property p_super;
      @(posedge clk) disable iff (rst)
      run && trap_d |=> sp_super_q && trap_q;
   endproperty
   a_super: assert property (p_super) else $error("trap not supervisor"); // [RULE_21]
endmodule

/* File: dv/ead_mem_model.sv */
module ead_mem_model (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Bus activity and stall length
   input wire logic busy,
   input wire logic [3:0] n_wait,
   // Stall request
   output logic bus_wait
);
   // --------
   // Slow memory
   // --------
   logic [3:0] age_q, age_d;
   // Saturates so a long instruction never wraps into a second stall
   assign age_d = (age_q == 4'hf) ? age_q : age_q + 4'h1;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         age_q <= 4'h0;
      end else begin
         age_q <= busy ? age_d : 4'h0;
      end
   end
   assign bus_wait = busy && (age_q >= 4'h2) && ({1'b0, age_q} < 5'h2 + {1'b0, n_wait});
endmodule

/* File: dv/ead_exec_tb.sv */
module ead_exec_tb;
   timeunit 1ns;
   timeprecision 100ps;
   import ead_pkg::*;
   // --------
   // Stimulus and observed signals
   // --------
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic start = 1'b0, resume = 1'b0, cond_true = 1'b0, bus_wait;
   ead_op_t op = op_move;
   ead_size_t sz = sz_long;
   logic [1:0] pf_cnt = 2'h2;
   logic [2:0] ea_mode = 3'h0, ea_reg = 3'h0;
   logic [3:0] req_cat = 4'h0, n_reads = 4'h0, n_writes = 4'h0, n_wait = 4'h0;
   logic [31:0] src = 32'h0, dst = 32'h0, pc_in = 32'h100, sp_in = 32'h1000;
   logic [15:0] imm = 16'h0, sr_in = 16'h2000, sr_q;
   logic [4:0] bit_num = 5'h0;
   logic [7:0] int_clks = 8'h0;
   logic [31:0] res_q, pc_q, sp_q, an_q, push_q;
   logic sp_super_q, trap_q, illegal_q, branch_q, done_q, busy_q, halted_q;
   logic [9:0] cycles_q;
   int n_mismatch = 0, checks = 0, lat;
   always #12.5 clk = ~clk;
   ead_exec ead_exec_inst (
      .clk, .rst, .start, .op, .sz, .pf_cnt, .resume, .ea_mode, .ea_reg, .req_cat, .src, .dst,
      .imm, .bit_num, .cond_true, .sr_in, .pc_in, .sp_in, .n_reads, .n_writes, .int_clks,
      .bus_wait, .res_q, .sr_q, .pc_q, .sp_q, .an_q, .push_q, .sp_super_q, .trap_q,
      .illegal_q, .branch_q, .done_q, .busy_q, .halted_q, .cycles_q
   );
   ead_mem_model ead_mem_model_inst (.clk, .rst, .busy(busy_q), .n_wait, .bus_wait);
   // --------
   // Compare and drive helpers
   // --------
   task automatic chk_v(input logic [31:0] got, exp);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_s(input logic [15:0] got, exp);
      chk_v(32'(got), 32'(exp));
   endtask
   task automatic chk_f(input logic got, exp);
      chk_v(32'(got), 32'(exp));
   endtask
   task automatic issue(input ead_op_t o, input logic [31:0] s, d);
      op = o;
      src = s;
      dst = d;
      start = 1'b1;
      @(posedge clk);
      #2 start = 1'b0;
   endtask
   task automatic wait_done();
      lat = 0;
      while (done_q !== 1'b1 && halted_q !== 1'b1 && lat < 400) begin
         @(posedge clk);
         #2 lat++;
      end
      if (lat >= 400) chk_f(done_q, 1'b1);
      @(posedge clk);
      #2;
   endtask
   task automatic go(input ead_op_t o, input logic [31:0] s, d);
      issue(o, s, d);
      wait_done();
   endtask
   // --------
   // Scenarios
   // --------
   task automatic t_reset();
      chk_s(sr_q, 16'h2000);
      chk_f(sp_super_q, 1'b1);
      chk_f(busy_q | done_q | halted_q, 1'b0);
      $display("test reset done");
   endtask
   task automatic t_move(input logic [3:0] w);
      n_reads = 4'h1;
      n_writes = 4'h1;
      int_clks = 8'h2;
      n_wait = w;
      sr_in = 16'h2013;
      go(op_move, 32'h8000_0000, 32'h0);
      chk_v(res_q, 32'h8000_0000);
      chk_s(sr_q, 16'h2018);
      chk_v(32'(cycles_q), 32'he + w);
      chk_v(32'(lat), 32'he + w);
      n_reads = 4'h0;
      n_writes = 4'h0;
      int_clks = 8'h0;
      n_wait = 4'h0;
      $display("test move done");
   endtask
   task automatic t_bcd();
      ead_op_t o[6] = '{op_dec_add, op_dec_add, op_dec_sub, op_dec_sub, op_dec_neg, op_dec_neg};
      logic [7:0] d[6] = '{8'h45, 8'h99, 8'h00, 8'h50, 8'h01, 8'h00};
      logic [7:0] s[6] = '{8'h38, 8'h01, 8'h01, 8'h25, 8'h55, 8'h55};
      logic [7:0] r[6] = '{8'h84, 8'h00, 8'h99, 8'h24, 8'h99, 8'h00};
      logic [5:0] x = 6'h09;
      logic [5:0] c = 6'h16;
      for (int i = 0; i < 6; i++) begin
         sr_in = {11'h100, x[i], 4'h4};
         go(o[i], {24'h0, s[i]}, {24'h0, d[i]});
         chk_v(res_q & 32'hff, {24'h0, r[i]});
         chk_s(sr_q & 16'hfff5, {11'h100, c[i], 1'b0, r[i] == 8'h0, 1'b0, c[i]});
      end
      $display("test decimal done");
   endtask
   task automatic t_bits();
      ead_op_t o[4] = '{op_bit_tst, op_bit_set, op_bit_clr, op_bit_inv};
      logic [31:0] one;
      logic [31:0] e[4];
      sr_in = 16'h201b;
      for (int m = 0; m < 2; m++) begin
         ea_mode = m ? 3'h2 : 3'h0;
         bit_num = m ? 5'h0d : 5'h04;
         one = m ? 32'h20 : 32'h10;
         e = '{32'h10, 32'h10 | one, 32'h10 & ~one, 32'h10 ^ one};
         for (int i = 0; i < 4; i++) begin
            go(o[i], 32'h0, 32'h10);
            chk_s(sr_q, m ? 16'h201f : 16'h201b);
            if (i > 0) chk_v(res_q & 32'hff, e[i]);
         end
      end
      ea_mode = 3'h0;
      $display("test bits done");
   endtask
   task automatic t_bounds();
      logic [31:0] d[4] = '{32'hffff, 32'hb, 32'ha, 32'h0};
      sr_in = 16'h0017;
      for (int i = 0; i < 4; i++) begin
         go(op_bounds, 32'ha, d[i]);
         chk_f(trap_q, i < 2);
         chk_s(sr_q, (i == 0) ? 16'h1f : 16'h17);
         chk_f(sp_super_q, i < 2);
      end
      $display("test bounds done");
   endtask
   task automatic t_loop();
      imm = 16'hfffc;
      sr_in = 16'h2013;
      cond_true = 1'b1;
      go(op_loop, 32'h0, 32'h5);
      chk_f(branch_q, 1'b0);
      cond_true = 1'b0;
      go(op_loop, 32'h0, 32'h5);
      chk_f(branch_q, 1'b1);
      chk_v(res_q & 32'hffff, 32'h4);
      chk_v(pc_q, 32'hfc);
      go(op_loop, 32'h0, 32'h0);
      chk_f(branch_q, 1'b0);
      chk_v(res_q & 32'hffff, 32'hffff);
      chk_s(sr_q, 16'h2013);
      $display("test loop done");
   endtask
   task automatic t_flags();
      ead_op_t o[8] = '{op_mark, op_mark, op_subtract_with_extend, op_subtract_with_extend, op_swap, op_setcc, op_setcc,
         op_from_sr};
      logic [31:0] s[8] = '{32'h0, 32'h0, 32'h0, 32'h1, 32'h12348000, 32'h0, 32'h0, 32'h0};
      logic [31:0] d[8] = '{32'h0, 32'h80, 32'h0, 32'h80, 32'h12348000, 32'h0, 32'h0, 32'h0};
      logic [15:0] f[8] = '{16'h2013, 16'h2013, 16'h2014, 16'h2000, 16'h2013, 16'h2013,
         16'h2013, 16'h0004};
      logic [31:0] r[8] = '{32'h80, 32'h80, 32'hff, 32'h7f, 32'h80001234, 32'hff, 32'h0, 32'h4};
      logic [31:0] m[8] = '{32'hff, 32'hff, 32'hff, 32'hff, 32'hffffffff, 32'hff, 32'hff,
         32'hffff};
      logic [15:0] e[8] = '{16'h2014, 16'h2018, 16'h2019, 16'h2002, 16'h2018, 16'h2013,
         16'h2013, 16'h0004};
      sz = sz_byte;
      for (int i = 0; i < 8; i++) begin
         sr_in = f[i];
         cond_true = (i == 5);
         go(o[i], s[i], d[i]);
         chk_v(res_q & m[i], r[i]);
         chk_s(sr_q, e[i]);
         chk_f(sp_super_q, f[i][13]);
      end
      $display("test flags done");
   endtask
   task automatic t_logic();
      ead_op_t o[7] = '{op_and_ccr, op_or_ccr, op_xor_ccr, op_and_sr, op_or_sr, op_xor_sr,
         op_to_sr};
      logic [15:0] v[7] = '{16'h11, 16'ha, 16'h1f, 16'hf1f, 16'h2700, 16'h2004, 16'h13};
      logic [15:0] f[7] = '{16'h201f, 16'h2000, 16'h2015, 16'h2015, 16'h5, 16'h2004, 16'h2000};
      logic [15:0] e[7] = '{16'h2011, 16'h200a, 16'h200a, 16'h15, 16'h2705, 16'h0, 16'h13};
      for (int i = 0; i < 7; i++) begin
         sr_in = f[i];
         imm = (i < 6) ? v[i] : 16'h0;
         go(o[i], (i < 6) ? 32'h0 : {16'h0, v[i]}, 32'h0);
         chk_s(sr_q, e[i]);
      end
      $display("test logic done");
   endtask
   task automatic t_stack();
      sr_in = 16'h2000;
      issue(op_rtr, 32'h13, 32'h4000);
      chk_s(sr_q, 16'h2013);
      chk_v(sp_q, 32'h1002);
      @(posedge clk);
      #2 chk_v(pc_q, 32'h4000);
      chk_v(sp_q, 32'h1006);
      wait_done();
      imm = 16'hfff8;
      go(op_link, 32'habcd, 32'h0);
      chk_v(push_q, 32'habcd);
      chk_v(an_q, 32'hffc);
      chk_v(sp_q, 32'hff4);
      chk_s(sr_q, 16'h2000);
      $display("test stack done");
   endtask
   task automatic t_modes();
      logic [3:0] c[12] = '{4'h9, 4'h1, 4'hf, 4'hd, 4'hd, 4'hf, 4'hf, 4'hf, 4'hf, 4'he, 4'he,
         4'hc};
      logic [3:0] miss;
      sz = sz_long;
      sr_in = 16'h0;
      for (int i = 0; i < 15; i++) begin
         ea_mode = (i < 7) ? 3'(i) : 3'h7;
         ea_reg = (i < 7) ? 3'h2 : 3'(i - 7);
         req_cat = (i < 12) ? c[i] : 4'h0;
         miss = (i < 12) ? ~c[i] & (c[i] + 4'h1) : 4'h0;
         if (i < 12) begin
            go(op_move, 32'(i), 32'h0);
            chk_f(illegal_q, 1'b0);
            chk_f(sp_super_q, 1'b0);
            chk_v(res_q, 32'(i));
            req_cat = c[i] | miss;
         end
         if (miss != 4'h0 || i >= 12) begin
            go(op_move, 32'hdead, 32'h0);
            chk_f(illegal_q, 1'b1);
            chk_f(sp_super_q, 1'b1);
            chk_v(res_q, 32'((i < 12) ? i : 11));
            chk_v(32'(cycles_q), 32'h4);
         end
      end
      ea_mode = 3'h0;
      req_cat = 4'h0;
      $display("test modes done");
   endtask
   task automatic t_pf();
      pf_cnt = 2'h1;
      start = 1'b1;
      repeat (4) @(posedge clk);
      #2 chk_f(busy_q, 1'b0);
      start = 1'b0;
      pf_cnt = 2'h2;
      @(posedge clk);
      #2 $display("test prefetch done");
   endtask
   task automatic t_stop();
      imm = 16'h2711;
      go(op_stop, 32'h0, 32'h0);
      chk_f(halted_q, 1'b1);
      chk_s(sr_q, 16'h2711);
      imm = 16'h0;
      issue(op_to_sr, 32'h0, 32'h0);
      repeat (3) @(posedge clk);
      #2 chk_s(sr_q, 16'h2711);
      chk_f(busy_q, 1'b0);
      resume = 1'b1;
      @(posedge clk);
      #2 resume = 1'b0;
      @(posedge clk);
      #2 chk_f(halted_q, 1'b0);
      $display("test stop done");
   endtask
   // --------
   // Sequence, watchdog and verdict
   // --------
   task automatic final_report();
      $display("checks=%0d mismatches=%0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   initial begin
      repeat (20) @(posedge clk);
      #2 rst = 1'b0;
      t_reset();
      t_move(4'h0);
      t_move(4'h3);
      t_bcd();
      t_bits();
      t_bounds();
      t_loop();
      t_flags();
      t_logic();
      t_stack();
      t_modes();
      t_pf();
      t_stop();
      final_report();
   end
   initial begin
      #(25 * 8000);
      n_mismatch++;
      final_report();
   end
endmodule
